// ### hdl/flash_host.v
// host controller that reads and sector-programs a parallel flash
// assumes the flash pins are wired directly, data lines shared by enable
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_host #(
  parameter [16:0] UNLOCK_A0    = `FH_UNLOCK_A0,
  parameter [7:0]  UNLOCK_D0    = `FH_UNLOCK_D0,
  parameter [16:0] UNLOCK_A1    = `FH_UNLOCK_A1,
  parameter [7:0]  UNLOCK_D1    = `FH_UNLOCK_D1,
  parameter [16:0] UNLOCK_A2    = `FH_UNLOCK_A2,
  parameter [7:0]  UNLOCK_D2    = `FH_UNLOCK_D2,
  parameter [23:0] TWC_CYC      = `FH_TWC_CYC,
  parameter [23:0] PWRUP_CYC    = `FH_PWRUP_CYC,
  parameter [23:0] LOAD_GAP_CYC = `FH_LOAD_GAP_CYC
) (
  input  wire        MCLK,
  input  wire        RESET,
  // user side
  input  wire        RD_REQ,
  input  wire [16:0] RD_ADDR,
  output wire        RD_READY,
  output reg         RD_VALID,
  output reg  [7:0]  RD_DATA,
  input  wire        PROG_REQ,
  input  wire [9:0]  PROG_SECTOR,
  output wire        PROG_READY,
  output wire        FILL_REQ,
  output reg  [6:0]  FILL_OFFSET,
  input  wire [7:0]  FILL_DATA,
  output reg         PROG_DONE,
  output reg         PROG_TIMEOUT,
  // flash pins
  output wire [16:0] ADDRESS_LINES,
  output wire [7:0]  DATA_LINES_OUT,
  input  wire [7:0]  DATA_LINES_IN,
  output wire        DATA_LINES_OE,
  output wire        CE_N,
  output wire        OE_N,
  output wire        WE_N
);

  localparam [3:0] S_PWRUP  = 4'h0;
  localparam [3:0] S_IDLE   = 4'h1;
  localparam [3:0] S_READ   = 4'h2;
  localparam [3:0] S_UNLOCK = 4'h3;
  localparam [3:0] S_FETCH  = 4'h4;
  localparam [3:0] S_LOAD   = 4'h5;
  localparam [3:0] S_POLLA  = 4'h6;
  localparam [3:0] S_POLLB  = 4'h7;
  localparam [3:0] S_WAIT   = 4'h8;

  reg  [3:0]  state_reg;
  reg  [23:0] timer_reg;
  reg  [1:0]  step_reg;
  reg  [9:0]  sector_reg;
  reg  [7:0]  last_byte_reg;
  reg  [7:0]  prev_poll_reg;
  reg         cyc_start;
  reg         cyc_wr;
  reg  [16:0] cyc_addr;
  reg  [7:0]  cyc_wdata;
  wire        cyc_busy;
  wire        cyc_done;
  wire [7:0]  cyc_rdata;
  wire [24:0] unlock_cur;

  ////////////////////////////////////////////////////////////////////////////
  // unlock step lookup, shared by address and data paths
  function [24:0] unlock_word;
    input [1:0] step;
    begin
      case (step)
        2'h0:    unlock_word = {UNLOCK_A0, UNLOCK_D0};
        2'h1:    unlock_word = {UNLOCK_A1, UNLOCK_D1};
        default: unlock_word = {UNLOCK_A2, UNLOCK_D2};
      endcase
    end
  endfunction

  flash_pin_cycle u_cycle (
    .clk         (MCLK),
    .rst         (RESET),
    .start       (cyc_start),
    .wr          (cyc_wr),
    .addr        (cyc_addr),
    .wdata       (cyc_wdata),
    .pin_data_in (DATA_LINES_IN),
    .busy        (cyc_busy),
    .done        (cyc_done),
    .rdata       (cyc_rdata),
    .addr_out    (ADDRESS_LINES),
    .data_out    (DATA_LINES_OUT),
    .data_oe     (DATA_LINES_OE),
    .ce_n        (CE_N),
    .oe_n        (OE_N),
    .we_n        (WE_N)
  );

  // address and data of the unlock step now due
  assign unlock_cur = unlock_word(step_reg);

  // requests are taken only when idle with no cycle running
  assign RD_READY   = (state_reg == S_IDLE) && !cyc_busy;
  assign PROG_READY = RD_READY;
  assign FILL_REQ   = (state_reg == S_FETCH);

  ////////////////////////////////////////////////////////////////////////////
  // main sequencer: power-up wait, reads, unlock, 128 loads, polling
  always @(posedge MCLK) begin
    if (RESET) begin
      state_reg     <= S_PWRUP;
      timer_reg     <= 24'h000000;
      step_reg      <= 2'h0;
      sector_reg    <= 10'h000;
      last_byte_reg <= 8'h00;
      prev_poll_reg <= 8'h00;
      cyc_start     <= 1'b0;
      cyc_wr        <= 1'b0;
      cyc_addr      <= 17'h00000;
      cyc_wdata     <= 8'h00;
      FILL_OFFSET   <= 7'h00;
      RD_VALID      <= 1'b0;
      RD_DATA       <= 8'h00;
      PROG_DONE     <= 1'b0;
      PROG_TIMEOUT  <= 1'b0;
    end else begin
      cyc_start    <= 1'b0;
      RD_VALID     <= 1'b0;
      PROG_DONE    <= 1'b0;
      PROG_TIMEOUT <= 1'b0;
      case (state_reg)
        S_PWRUP: begin
          // wait out the device power-on delay
          if (timer_reg == PWRUP_CYC) begin
            state_reg <= S_IDLE;
          end else begin
            timer_reg <= timer_reg + 24'h000001;
          end
        end
        S_IDLE: begin
          if (RD_REQ && RD_READY) begin
            cyc_addr  <= RD_ADDR;
            cyc_wr    <= 1'b0;
            cyc_start <= 1'b1;
            state_reg <= S_READ;
          end else if (PROG_REQ && PROG_READY) begin
            sector_reg  <= PROG_SECTOR;
            step_reg    <= 2'h0;
            FILL_OFFSET <= 7'h00;
            state_reg   <= S_UNLOCK;
          end
        end
        S_READ: begin
          if (cyc_done) begin
            RD_DATA   <= cyc_rdata;
            RD_VALID  <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_UNLOCK: begin
          // three command writes before any load
          if (!cyc_busy && !cyc_start) begin
            if (step_reg == 2'h3) begin
              state_reg <= S_FETCH;
            end else begin
              cyc_addr  <= unlock_cur[24:8];
              cyc_wdata <= unlock_cur[7:0];
              cyc_wr    <= 1'b1;
              cyc_start <= 1'b1;
              step_reg  <= step_reg + 2'h1;
            end
          end
        end
        S_FETCH: begin
          // user supplies the byte in this cycle
          cyc_addr      <= {sector_reg, FILL_OFFSET};
          cyc_wdata     <= FILL_DATA;
          last_byte_reg <= FILL_DATA;
          cyc_wr        <= 1'b1;
          cyc_start     <= 1'b1;
          state_reg     <= S_LOAD;
        end
        S_LOAD: begin
          // every offset loaded, gap far below 150 us
          if (cyc_done) begin
            if (FILL_OFFSET == 7'h7F) begin
              timer_reg <= 24'h000000;
              state_reg <= S_WAIT;
            end else begin
              FILL_OFFSET <= FILL_OFFSET + 7'h01;
              state_reg   <= S_FETCH;
            end
          end
        end
        S_WAIT: begin
          // let the load window close before polling
          if (timer_reg == LOAD_GAP_CYC) begin
            timer_reg <= 24'h000000;
            state_reg <= S_POLLA;
          end else begin
            timer_reg <= timer_reg + 24'h000001;
          end
        end
        S_POLLA: begin
          // read the last loaded location
          cyc_addr  <= {sector_reg, 7'h7F};
          cyc_wr    <= 1'b0;
          cyc_start <= 1'b1;
          state_reg <= S_POLLB;
        end
        S_POLLB: begin
          timer_reg <= timer_reg + 24'h000001;
          if (cyc_done) begin
            prev_poll_reg <= cyc_rdata;
            // done when bit 7 true and bit 6 stable
            if (cyc_rdata[7] == last_byte_reg[7] &&
                cyc_rdata[6] == prev_poll_reg[6]) begin
              PROG_DONE <= 1'b1;
              state_reg <= S_IDLE;
            end else if (timer_reg >= TWC_CYC) begin
              PROG_TIMEOUT <= 1'b1;
              state_reg    <= S_IDLE;
            end else begin
              state_reg <= S_POLLA;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

// ### hdl/flash_host_map.vh
// constants for the parallel flash host controller
// assumes a 50 MHz MCLK and a 128K x 8 sector-programmed flash on the pins
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH

// geometry
`define FH_ADDR_W        17
`define FH_SECTOR_BYTES  128
`define FH_OFFSET_W      7
// unlock sequence defaults (arbitrary, override by parameter)
`define FH_UNLOCK_A0     17'h05555
`define FH_UNLOCK_D0     8'hAA
`define FH_UNLOCK_A1     17'h02AAA
`define FH_UNLOCK_D1     8'h55
`define FH_UNLOCK_A2     17'h05555
`define FH_UNLOCK_D2     8'hA0
// timing counts in cycles of the 20 ns clock, sized for their registers
// load gap 150 us: the whole load window has closed before polling starts,
// so a read of old data cannot be mistaken for the end of programming
`define FH_LOAD_GAP_CYC  24'h001D4C
// write strobe about 80 ns, far above the strobe noise filter
`define FH_PULSE_CYC     4'h3
// read access 200 ns
`define FH_READ_CYC      4'hA
// sector program limit 20 ms, also the polling timeout
`define FH_TWC_CYC       24'h0F4240
// power-on wait 20 ms, above the device's own power-on delay
`define FH_PWRUP_CYC     24'h0F4240
`endif

// ### hdl/flash_pin_cycle.v
// one bus cycle on the flash pins: a read or a write strobe
// assumes the caller holds addr/data stable while busy is high
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_pin_cycle (
  input  wire        clk,
  input  wire        rst,
  input  wire        start,
  input  wire        wr,
  input  wire [16:0] addr,
  input  wire [7:0]  wdata,
  input  wire [7:0]  pin_data_in,
  output reg         busy,
  output reg         done,
  output reg  [7:0]  rdata,
  output reg  [16:0] addr_out,
  output reg  [7:0]  data_out,
  output reg         data_oe,
  output reg         ce_n,
  output reg         oe_n,
  output reg         we_n
);

  localparam [3:0] PULSE_CYC = `FH_PULSE_CYC;
  localparam [3:0] READ_CYC  = `FH_READ_CYC;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_SET  = 2'h1;
  localparam [1:0] S_ACT  = 2'h2;
  localparam [1:0] S_HOLD = 2'h3;

  reg [1:0] state_reg;
  reg [3:0] cnt_reg;
  reg [7:0] din_s1_reg;
  reg [7:0] din_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop sampling of the data pins
  always @(posedge clk) begin
    din_s1_reg <= pin_data_in;
    din_s2_reg <= din_s1_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // address settles before strobe, strobe held long enough to pass filter
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 4'h0;
      busy      <= 1'b0;
      done      <= 1'b0;
      rdata     <= 8'h00;
      addr_out  <= 17'h00000;
      data_out  <= 8'h00;
      data_oe   <= 1'b0;
      ce_n      <= 1'b1;
      oe_n      <= 1'b1;
      we_n      <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            busy      <= 1'b1;
            addr_out  <= addr;
            data_out  <= wdata;
            data_oe   <= wr;
            state_reg <= S_SET;
          end
        end
        S_SET: begin
          // ce and we low together, oe high for a load
          ce_n      <= 1'b0;
          we_n      <= ~wr;
          oe_n      <= wr;
          cnt_reg   <= wr ? PULSE_CYC : READ_CYC;
          state_reg <= S_ACT;
        end
        S_ACT: begin
          if (cnt_reg == 4'h0) begin
            // we, oe and ce rise together, data captured there
            we_n      <= 1'b1;
            oe_n      <= 1'b1;
            ce_n      <= 1'b1;
            rdata     <= din_s2_reg;
            state_reg <= S_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        S_HOLD: begin
          data_oe   <= 1'b0;
          busy      <= 1'b0;
          done      <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

// ### sim/flash_host_chk.sv
// assertions on the pins and user strobes of the flash host
// assumes it is bound into flash_host with one clock and a sync RESET
`timescale 1ns/1ps
module flash_host_chk #(
  parameter [23:0] PWRUP_CYC = 24'h000032
) (
  input wire        MCLK,
  input wire        RESET,
  input wire        RD_READY,
  input wire        RD_VALID,
  input wire        PROG_READY,
  input wire        FILL_REQ,
  input wire [16:0] ADDRESS_LINES,
  input wire [7:0]  DATA_LINES_OUT,
  input wire        DATA_LINES_OE,
  input wire        CE_N,
  input wire        OE_N,
  input wire        WE_N
);
  reg [23:0] up_reg;
  ////////////////////////////////////////////////////////////////////////////
  // cycles since reset release, saturating at the power-up count
  always @(posedge MCLK) begin
    if (RESET)
      up_reg <= 24'h000000;
    else if (up_reg != PWRUP_CYC)
      up_reg <= up_reg + 24'h000001;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  property p_oe_free; DATA_LINES_OE |-> OE_N; endproperty
  a_oe_free: assert property (p_oe_free)
    else $error("host drives data during a read");
  property p_rd_we; !CE_N && !OE_N |-> WE_N; endproperty
  a_rd_we: assert property (p_rd_we)
    else $error("strobe low during a read");
  property p_load; !WE_N |-> OE_N && DATA_LINES_OE; endproperty
  a_load: assert property (p_load)
    else $error("write without driven data");
  property p_hold;
    !WE_N && !$past(WE_N) |->
      $stable(ADDRESS_LINES) && $stable(DATA_LINES_OUT);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address or data moved under the strobe");
  property p_width; $fell(WE_N) |-> !WE_N [*3]; endproperty
  a_width: assert property (p_width)
    else $error("write strobe too short");
  property p_rst;
    $fell(RESET) |-> CE_N && OE_N && WE_N && !RD_READY;
  endproperty
  a_rst: assert property (p_rst)
    else $error("pins not idle after reset");
  property p_up; RD_READY |-> up_reg >= PWRUP_CYC; endproperty
  a_up: assert property (p_up)
    else $error("ready before power-up delay");
  property p_fill;
    FILL_REQ |-> !PROG_READY ##1 !RD_VALID ##[0:3] $fell(WE_N);
  endproperty
  a_fill: assert property (p_fill)
    else $error("byte fetch while idle");
endmodule
bind flash_host flash_host_chk #(.PWRUP_CYC(PWRUP_CYC)) chk_u (.MCLK, .RESET,
  .RD_READY, .RD_VALID, .PROG_READY, .FILL_REQ, .ADDRESS_LINES,
  .DATA_LINES_OUT, .DATA_LINES_OE, .CE_N, .OE_N, .WE_N);

// ### sim/flash_dev_model.sv
// behavioural sector flash seen at its pins
// assumes the host drives select, enables, strobe and the data wire level
`timescale 1ns/1ps
module flash_dev_model #(
  parameter [74:0] UNLOCK = {17'h05555, 8'hAA, 17'h02AAA, 8'h55,
                             17'h05555, 8'hA0},
  parameter        WIN_NS = 300,
  parameter        PWR_NS = 500
) (
  input  wire [16:0] addr,
  input  wire [7:0]  din,
  input  wire        ce_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire        slow,
  output reg  [7:0]  q
);
  reg [7:0]   mem [0:131071];
  reg [7:0]   lat [0:127];
  reg [127:0] got;
  reg [16:0]  a_l;
  reg [9:0]   sec;
  reg [7:0]   last;
  reg [1:0]   st;
  reg         loading, busy, pend, tog;
  realtime    t_fall, t_rise, t_end;
  integer     i;
  wire        strb_n = ce_n | we_n;
  ////////////////////////////////////////////////////////////////////////////
  // array preset to a known pattern
  initial begin
    for (i = 0; i < 131072; i = i + 1)
      mem[i] = i[7:0] ^ 8'h5A;
    {st, loading, busy, pend, tog, got, q} = 0;
    t_fall = 0;
    t_rise = 0;
    t_end  = 0;
  end
  // address on the later falling edge of select and strobe
  always @(negedge strb_n) begin
    t_fall = $realtime;
    a_l = addr;
  end
  // data on the first rising edge, with inhibits and glitch filter
  always @(posedge strb_n) begin
    if (oe_n && !busy && $realtime - t_fall >= 15 && $realtime >= PWR_NS) begin
      if (loading || st == 2'h3) begin
        if (!loading)
          sec = a_l[16:7];
        loading = 1'b1;
        lat[a_l[6:0]] = din;
        got[a_l[6:0]] = 1'b1;
        last = din;
        t_rise = $realtime;
      end else if ({a_l, din} == UNLOCK[74 - 25 * st -: 25]) begin
        st = st + 2'h1;
      end else begin
        st = 2'h0;
        busy = 1'b1;
        t_end = $realtime + 2000;
      end
    end
  end
  // window close, then erase and program the sector under a timer
  always #10 begin
    if (loading && $realtime - t_rise > WIN_NS) begin
      {loading, st, busy, pend} = 5'h03;
      t_end = $realtime + (slow ? 60000 : 2000);
    end
    if (busy && $realtime >= t_end) begin
      for (i = 0; i < 128; i = i + 1)
        if (pend)
          mem[{sec, i[6:0]}] = got[i] ? lat[i] : 8'hFF;
      {busy, pend, got} = 0;
    end
  end
  // status toggle on each read start while busy
  always @(negedge (ce_n | oe_n)) if (busy) tog = ~tog;
  // read data, polling status, or a drifting bus when released
  always @(ce_n, oe_n, we_n, addr, busy, tog) begin
    if (!ce_n && !oe_n && we_n)
      q = busy ? {~last[7], tog, last[5:0]} : mem[addr];
    else
      q = ~q;
  end
endmodule

// ### sim/test_sector_flash_program_control.sv
// self-checking bench for the flash host against a device model
// assumes flash_host, the device model and the bound checker are compiled
`timescale 1ns/1ps
module test_sector_flash_program_control;
  reg         MCLK, RESET, RD_REQ, PROG_REQ, slow;
  reg  [16:0] RD_ADDR;
  reg  [9:0]  PROG_SECTOR;
  reg  [7:0]  key;
  wire [6:0]  FILL_OFFSET;
  wire [7:0]  FILL_DATA = {1'b0, FILL_OFFSET} ^ key;
  wire [7:0]  RD_DATA, DATA_LINES_OUT, dev_q;
  wire [7:0]  DATA_LINES_IN = DATA_LINES_OE ? DATA_LINES_OUT : dev_q;
  wire [16:0] ADDRESS_LINES;
  wire        RD_READY, RD_VALID, PROG_READY, FILL_REQ, PROG_DONE;
  wire        PROG_TIMEOUT, DATA_LINES_OE, CE_N, OE_N, WE_N;
  integer     n_errors, checked, k;
  ////////////////////////////////////////////////////////////////////////////
  flash_host #(.TWC_CYC(24'h0007D0), .PWRUP_CYC(24'h000032),
    .LOAD_GAP_CYC(24'h000014)) dut_u (.MCLK, .RESET, .RD_REQ, .RD_ADDR,
    .RD_READY, .RD_VALID, .RD_DATA, .PROG_REQ, .PROG_SECTOR, .PROG_READY,
    .FILL_REQ, .FILL_OFFSET, .FILL_DATA, .PROG_DONE, .PROG_TIMEOUT,
    .ADDRESS_LINES, .DATA_LINES_OUT, .DATA_LINES_IN, .DATA_LINES_OE, .CE_N,
    .OE_N, .WE_N);
  flash_dev_model dev_u (.addr(ADDRESS_LINES), .din(DATA_LINES_IN),
    .ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N), .slow(slow), .q(dev_q));
  ////////////////////////////////////////////////////////////////////////////
  task check(input string what, input [7:0] exp, input [7:0] seen);
    checked = checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait: 0 ready, 1 read valid, 2 program end
  task wait_for(input integer sel);
    reg hit;
    hit = 1'b0;
    for (k = 0; k < 9000 && !hit; k = k + 1) begin
      @(posedge MCLK);
      #1;
      hit = (sel == 0 ? RD_READY : sel == 1 ? RD_VALID
             : PROG_DONE | PROG_TIMEOUT) === 1'b1;
    end
    if (!hit)
      check("wait", 8'h01, 8'h00);
  endtask
  task rd(input [16:0] a, input [7:0] exp);
    wait_for(0);
    @(posedge MCLK) {RD_ADDR, RD_REQ} <= {a, 1'b1};
    @(posedge MCLK) RD_REQ <= 1'b0;
    wait_for(1);
    check("read", exp, RD_DATA);
  endtask
  task prog(input [9:0] s, input [7:0] kk, input sl);
    wait_for(0);
    @(posedge MCLK) {PROG_SECTOR, key, slow, PROG_REQ} <= {s, kk, sl, 1'b1};
    @(posedge MCLK) PROG_REQ <= 1'b0;
    wait_for(2);
    check("done", {7'h00, ~sl}, {7'h00, PROG_DONE});
    check("tmo", {7'h00, sl}, {7'h00, PROG_TIMEOUT});
  endtask
  // program a sector, read its ends and middle
  task t_sector(input [9:0] s, input [7:0] kk);
    prog(s, kk, 1'b0);
    rd({s, 7'h00}, kk);
    rd({s, 7'h7F}, kk ^ 8'h7F);
    rd({s, 7'h40}, kk ^ 8'h40);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // free-running 50 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  // watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge MCLK);
    n_errors = n_errors + 1;
    end_of_test;
  end
  // main sequence
  initial begin
    {n_errors, checked, RESET, RD_REQ, PROG_REQ, slow} = {32'h0, 32'h0, 4'h8};
    {RD_ADDR, PROG_SECTOR, key} = 35'h0;
    repeat (5) @(posedge MCLK);
    RESET <= 1'b0;
    repeat (10) @(posedge MCLK);
    #1 check("ready", 8'h00, {7'h00, RD_READY});
    check("pready", 8'h00, {7'h00, PROG_READY});
    rd(17'h00000, 8'h5A);
    rd(17'h1FFFF, 8'hA5);
    t_sector(10'h003, 8'h3C);
    rd({10'h004, 7'h01}, 8'h5B);
    t_sector(10'h000, 8'h81);
    t_sector(10'h3FF, 8'hC6);
    prog(10'h200, 8'hE7, 1'b1);
    repeat (1500) @(posedge MCLK);
    rd({10'h200, 7'h05}, 8'hE2);
    end_of_test;
  end
endmodule
